// >>> logic/tdmf_pkg.sv
// Purpose: shared constants for the highway frame timing block
// Assumes: 40 MHz system clock, AHB-Lite register access
// Notes: rate codes 0 = 2.048, 1 = 4.096, 2 = 8.192 (Mbit/s or MHz)
package tdmf_pkg;
  // ------------------------------------------------------------
  // clock and time
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int CLK_PERIOD_NS = 25;
  localparam int LOCK_TIME_US = 250;
  localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
  localparam int SETTLE_TIME_NS = 200;
  localparam int SETTLE_CYCLES = SETTLE_TIME_NS / CLK_PERIOD_NS;
  localparam int STALL_CYCLES = 64;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [15:0] ADDR_GEN_CMD = 16'h0000;
  localparam logic [15:0] ADDR_STATUS = 16'h0004;
  localparam logic [7:0] PAGE_RX_CFG = 8'h01;
  localparam logic [7:0] PAGE_TX_CFG = 8'h02;
  localparam logic [1:0] WIN_MODE = 2'h1;

  // general command fields
  localparam int GEN_EDGE_BIT = 1;
  localparam int GEN_POL_BIT = 2;
  localparam int GEN_CKRATE_LSB = 4;
  localparam logic [5:0] GEN_CMD_RESET = 6'h00;
  // status fields
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_POS_LSB = 4;

  // highway config fields: {rate[13:12], slot[11:5], bit[4:2], frac[1:0]}
  localparam int CFG_W = 14;
  localparam int CFG_Q_W = 12;
  localparam int CFG_RATE_LSB = 12;
  localparam logic [13:0] CFG_RESET = 14'h0000;

  // ------------------------------------------------------------
  // timing units
  // ------------------------------------------------------------
  localparam int POS_W = 13;
  localparam int UNIT_W = 17;
  localparam logic [16:0] TWO_SLOT_UNITS = 17'h00040;
  localparam logic [16:0] LL_BASE_UNITS = 17'h00004;
  localparam logic signed [16:0] FI_NEXT_UNITS = 17'sh00080;
  localparam logic signed [16:0] FI_LATE_UNITS = -17'sh00f80;
  localparam logic [1:0] RATE_8192 = 2'h2;

  typedef enum logic [1:0] {
    TDMF_WAIT_LOCK = 2'b00,
    TDMF_SETTLE = 2'b01,
    TDMF_RUN = 2'b10
  } tdmf_state_t;
endpackage : tdmf_pkg

// >>> logic/tdmf_mode_store.sv
// Purpose: per transmit slot mode memory, one word per slot
// Assumes: single write port, single registered read port
// Notes: a read in the same cycle as a write to the same word returns old data
`timescale 1ns/1ps
`default_nettype none
module tdmf_mode_store #(
  parameter int DEPTH = 4096,
  parameter int AW = 12,
  parameter int DW = 1
) (
  input wire logic sys_clk_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic re_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk_i) begin
    if (ce_i && we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    if (ce_i && re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule : tdmf_mode_store
`default_nettype wire

// >>> logic/tdmf_frame_timing.sv
// Purpose: virtual frame timing and slot latency decision for TDM highways
// Assumes: highway clock and frame sync synchronous to sys_clk_i, slower by 4x+
// Notes: offsets resolve in half highway-clock cycles
//
// Overview of operation
// - frame sync starts physical frame; slot0 placeable
// - per-highway slot offset up to 31/63/127
// - extra bit offset up to seven bits
// - fractional offset 0, 1/4, 1/2, 3/4 bit
// - rx and tx offsets held independently per highway
// - offsets count in the highway's own bit rate
// - polarity bit one: sync active high
// - edge bit one: sample sync on rising edge
// - zero offsets: slot0 bit0 at sync edge
// - faster clock: offsets scaled in half cycles
// - wait for lock, settle 200 ns
// - reset accepted without clock relationship
// - per transmit slot low latency or integrity
// - low latency: current frame if late enough
// - separation two rx slots plus (4+i) units
// - positions include highway offsets on both sides
// - low latency delay at most 134 us
// - integrity delay at most 378 us
// - integrity frame N+1, N+2 or N+3 by offsets
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tdmf_frame_timing #(
  parameter int NUM_HWY = 32,
  parameter int SLOT_W = 7,
  parameter int LOCK_CYC = tdmf_pkg::LOCK_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic highway_clock_i,
  input wire logic frame_sync_i,
  output logic [NUM_HWY-1:0] rx_vframe_o,
  output logic [NUM_HWY-1:0] tx_vframe_o,
  output logic device_ready_o,
  input wire logic dec_req_i,
  input wire logic [4:0] dec_rx_hwy_i,
  input wire logic [SLOT_W-1:0] dec_rx_slot_i,
  input wire logic [4:0] dec_tx_hwy_i,
  input wire logic [SLOT_W-1:0] dec_tx_slot_i,
  output logic dec_valid_o,
  output logic dec_fi_o,
  output logic [1:0] dec_frames_o
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // offset in half highway-clock cycles
  function automatic logic [tdmf_pkg::POS_W-1:0] half_off(
    input logic [tdmf_pkg::CFG_W-1:0] cfg, input logic [1:0] ck_rate);
    logic [1:0] rate;
    logic [1:0] sh;
    logic [tdmf_pkg::POS_W+2:0] q;
    rate = cfg[tdmf_pkg::CFG_RATE_LSB +: 2];
    sh = (ck_rate >= rate) ? 2'(ck_rate - rate) : 2'h0;
    q = (tdmf_pkg::POS_W+3)'(cfg[tdmf_pkg::CFG_Q_W-1:0]) << sh;
    return q[tdmf_pkg::POS_W:1];
  endfunction : half_off

  // quarter bits at own rate into 8.192 quarter-bit units
  function automatic logic [tdmf_pkg::UNIT_W-1:0] to_units(
    input logic [tdmf_pkg::UNIT_W-1:0] q, input logic [1:0] rate);
    logic [1:0] sh;
    sh = (rate >= tdmf_pkg::RATE_8192) ? 2'h0 : 2'(tdmf_pkg::RATE_8192 - rate);
    return q << sh;
  endfunction : to_units

  // ------------------------------------------------------------
  // ahb-lite slave
  // ------------------------------------------------------------
  logic [5:0] gen_cmd, next_gen_cmd;
  logic [tdmf_pkg::CFG_W-1:0] rx_cfg [NUM_HWY];
  logic [tdmf_pkg::CFG_W-1:0] tx_cfg [NUM_HWY];
  logic ap_write, next_ap_write;
  logic [15:0] ap_addr, next_ap_addr;
  logic [31:0] next_rdata;
  logic [tdmf_pkg::POS_W-1:0] pos;
  logic locked = 1'b0;
  tdmf_pkg::tdmf_state_t state;
  logic ap_take;
  logic dp_is_rx, dp_is_tx, dp_is_mode;

  assign ap_take = hsel_i && htrans_i[1] && hready_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign dp_is_rx = ap_write && (ap_addr[15:8] == tdmf_pkg::PAGE_RX_CFG);
  assign dp_is_tx = ap_write && (ap_addr[15:8] == tdmf_pkg::PAGE_TX_CFG);
  assign dp_is_mode = ap_write && (ap_addr[15:14] == tdmf_pkg::WIN_MODE);

  always_comb begin
    next_ap_write = ap_take && hwrite_i;
    next_ap_addr = ap_take ? haddr_i[15:0] : ap_addr;
    next_gen_cmd = gen_cmd;
    if (ap_write && ap_addr == tdmf_pkg::ADDR_GEN_CMD) begin
      next_gen_cmd = hwdata_i[5:0];
    end
    next_rdata = 32'h0000_0000;
    if (ap_take && !hwrite_i) begin
      if (haddr_i[15:0] == tdmf_pkg::ADDR_GEN_CMD) begin
        next_rdata = {26'h0, gen_cmd};
      end else if (haddr_i[15:0] == tdmf_pkg::ADDR_STATUS) begin
        next_rdata[tdmf_pkg::STAT_READY_BIT] = (state == tdmf_pkg::TDMF_RUN);
        next_rdata[tdmf_pkg::STAT_LOCK_BIT] = locked;
        next_rdata[tdmf_pkg::STAT_POS_LSB +: tdmf_pkg::POS_W] = pos;
      end else if (haddr_i[15:8] == tdmf_pkg::PAGE_RX_CFG && 32'(haddr_i[7:2]) < NUM_HWY) begin
        next_rdata = 32'(rx_cfg[haddr_i[6:2]]);
      end else if (haddr_i[15:8] == tdmf_pkg::PAGE_TX_CFG && 32'(haddr_i[7:2]) < NUM_HWY) begin
        next_rdata = 32'(tx_cfg[haddr_i[6:2]]);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ap_write <= 1'b0;
      ap_addr <= 16'h0000;
      hrdata_o <= 32'h0000_0000;
      gen_cmd <= tdmf_pkg::GEN_CMD_RESET;
    end else if (ce_i) begin
      ap_write <= next_ap_write;
      ap_addr <= next_ap_addr;
      hrdata_o <= next_rdata;
      gen_cmd <= next_gen_cmd;
    end
  end

  // separate rx and tx tables, each word written alone
  genvar g;
  generate
    for (g = 0; g < NUM_HWY; g++) begin : g_cfg
      always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
          rx_cfg[g] <= tdmf_pkg::CFG_RESET;
          tx_cfg[g] <= tdmf_pkg::CFG_RESET;
        end else if (ce_i) begin
          if (dp_is_rx && ap_addr[7:2] == 6'(g)) begin
            rx_cfg[g] <= hwdata_i[tdmf_pkg::CFG_W-1:0];
          end
          if (dp_is_tx && ap_addr[7:2] == 6'(g)) begin
            tx_cfg[g] <= hwdata_i[tdmf_pkg::CFG_W-1:0];
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // lock and reset sequence
  // ------------------------------------------------------------
  // lock survives a reset only while the highway clock keeps running
  logic hck_q, next_hck_q;
  logic [7:0] gap = 8'h00;
  logic [7:0] next_gap;
  logic next_locked;
  logic [15:0] seq_cnt, next_seq_cnt;
  tdmf_pkg::tdmf_state_t next_state;
  logic tick, rise, fall;

  // power-up value only: srst_i leaves the lock flag alone
  assign rise = highway_clock_i && !hck_q;
  assign fall = !highway_clock_i && hck_q;
  assign tick = rise || fall;

  always_comb begin
    next_hck_q = highway_clock_i;
    next_gap = tick ? 8'(tdmf_pkg::STALL_CYCLES) : ((gap != 8'h00) ? gap - 8'h01 : 8'h00);
    next_locked = locked && (gap != 8'h00);
    next_state = state;
    next_seq_cnt = seq_cnt;
    if (srst_i) begin
      next_seq_cnt = 16'h0000;
      next_state = next_locked ? tdmf_pkg::TDMF_SETTLE : tdmf_pkg::TDMF_WAIT_LOCK;
    end else begin
      unique case (state)
        tdmf_pkg::TDMF_WAIT_LOCK: begin
          if (gap == 8'h00) begin
            next_seq_cnt = 16'h0000;
          end else if (32'(seq_cnt) >= LOCK_CYC - 1) begin
            next_locked = 1'b1;
            next_seq_cnt = 16'h0000;
            next_state = tdmf_pkg::TDMF_SETTLE;
          end else begin
            next_seq_cnt = seq_cnt + 16'h0001;
          end
        end
        tdmf_pkg::TDMF_SETTLE: begin
          if (32'(seq_cnt) >= tdmf_pkg::SETTLE_CYCLES - 1) begin
            next_state = tdmf_pkg::TDMF_RUN;
          end else begin
            next_seq_cnt = seq_cnt + 16'h0001;
          end
        end
        tdmf_pkg::TDMF_RUN: begin
          if (!next_locked) begin
            next_state = tdmf_pkg::TDMF_WAIT_LOCK;
            next_seq_cnt = 16'h0000;
          end
        end
        default: begin
          next_state = tdmf_pkg::TDMF_WAIT_LOCK;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (ce_i) begin
      hck_q <= next_hck_q;
      gap <= next_gap;
      locked <= next_locked;
      state <= next_state;
      seq_cnt <= next_seq_cnt;
    end
  end

  assign device_ready_o = (state == tdmf_pkg::TDMF_RUN);

  // ------------------------------------------------------------
  // frame position and virtual frame starts
  // ------------------------------------------------------------
  logic sync_edge, sync_hit, run;
  logic [tdmf_pkg::POS_W-1:0] pos_now, next_pos;
  logic [1:0] ck_rate;
  logic [NUM_HWY-1:0] rx_hit, tx_hit, next_rx_vf, next_tx_vf;

  assign run = (state == tdmf_pkg::TDMF_RUN);
  assign ck_rate = gen_cmd[tdmf_pkg::GEN_CKRATE_LSB +: 2];
  assign sync_edge = gen_cmd[tdmf_pkg::GEN_EDGE_BIT] ? rise : fall;
  assign sync_hit = sync_edge && (frame_sync_i == gen_cmd[tdmf_pkg::GEN_POL_BIT]);
  assign pos_now = sync_hit ? '0 : pos + 1'b1;

  generate
    for (g = 0; g < NUM_HWY; g++) begin : g_vf
      assign rx_hit[g] = (pos_now == half_off(rx_cfg[g], ck_rate));
      assign tx_hit[g] = (pos_now == half_off(tx_cfg[g], ck_rate));
    end
  endgenerate

  always_comb begin
    next_pos = (run && tick) ? pos_now : pos;
    next_rx_vf = (run && tick) ? rx_hit : '0;
    next_tx_vf = (run && tick) ? tx_hit : '0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pos <= '0;
      rx_vframe_o <= '0;
      tx_vframe_o <= '0;
    end else if (ce_i) begin
      pos <= next_pos;
      rx_vframe_o <= next_rx_vf;
      tx_vframe_o <= next_tx_vf;
    end
  end

  // ------------------------------------------------------------
  // transmit frame decision
  // ------------------------------------------------------------
  logic s1_valid, next_s1_valid;
  logic [4:0] s1_rx_hwy, s1_tx_hwy, next_s1_rx_hwy, next_s1_tx_hwy;
  logic [SLOT_W-1:0] s1_rx_slot, s1_tx_slot, next_s1_rx_slot, next_s1_tx_slot;
  logic slot_fi, take;
  logic [tdmf_pkg::UNIT_W-1:0] rx_off_u, tx_off_u, rx_pos_u, tx_pos_u, need_u;
  logic signed [tdmf_pkg::UNIT_W-1:0] diff_u;
  logic [1:0] rr, tr, next_frames;
  logic next_valid, next_fi;

  assign take = ce_i && run && dec_req_i;

  tdmf_mode_store #(
    .DEPTH(NUM_HWY << SLOT_W),
    .AW(5 + SLOT_W),
    .DW(1)
  ) u_mode_store (
    .sys_clk_i(sys_clk_i),
    .ce_i(ce_i),
    .we_i(dp_is_mode),
    .waddr_i(ap_addr[2 +: 5 + SLOT_W]),
    .wdata_i(hwdata_i[0]),
    .re_i(take),
    .raddr_i({dec_tx_hwy_i, dec_tx_slot_i}),
    .rdata_o(slot_fi)
  );

  always_comb begin
    next_s1_valid = take;
    next_s1_rx_hwy = take ? dec_rx_hwy_i : s1_rx_hwy;
    next_s1_tx_hwy = take ? dec_tx_hwy_i : s1_tx_hwy;
    next_s1_rx_slot = take ? dec_rx_slot_i : s1_rx_slot;
    next_s1_tx_slot = take ? dec_tx_slot_i : s1_tx_slot;
    rr = rx_cfg[s1_rx_hwy][tdmf_pkg::CFG_RATE_LSB +: 2];
    tr = tx_cfg[s1_tx_hwy][tdmf_pkg::CFG_RATE_LSB +: 2];
    rx_off_u = to_units(17'(rx_cfg[s1_rx_hwy][tdmf_pkg::CFG_Q_W-1:0]), rr);
    tx_off_u = to_units(17'(tx_cfg[s1_tx_hwy][tdmf_pkg::CFG_Q_W-1:0]), tr);
    rx_pos_u = to_units(17'({s1_rx_slot, 5'h00}), rr) + rx_off_u;
    tx_pos_u = to_units(17'({s1_tx_slot, 5'h00}), tr) + tx_off_u;
    need_u = rx_pos_u + to_units(tdmf_pkg::TWO_SLOT_UNITS, rr)
           + tdmf_pkg::LL_BASE_UNITS + 17'(s1_tx_hwy);
    diff_u = $signed(tx_off_u) - $signed(rx_off_u);
    if (slot_fi) begin
      if (diff_u >= tdmf_pkg::FI_NEXT_UNITS) begin
        next_frames = 2'h1;
      end else if (diff_u < tdmf_pkg::FI_LATE_UNITS) begin
        next_frames = 2'h3;
      end else begin
        next_frames = 2'h2;
      end
    end else begin
      next_frames = (tx_pos_u >= need_u) ? 2'h0 : 2'h1;
    end
    next_valid = s1_valid;
    next_fi = slot_fi;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s1_valid <= 1'b0;
      s1_rx_hwy <= 5'h00;
      s1_tx_hwy <= 5'h00;
      s1_rx_slot <= '0;
      s1_tx_slot <= '0;
      dec_valid_o <= 1'b0;
      dec_fi_o <= 1'b0;
      dec_frames_o <= 2'h0;
    end else if (ce_i) begin
      s1_valid <= next_s1_valid;
      s1_rx_hwy <= next_s1_rx_hwy;
      s1_tx_hwy <= next_s1_tx_hwy;
      s1_rx_slot <= next_s1_rx_slot;
      s1_tx_slot <= next_s1_tx_slot;
      dec_valid_o <= next_valid;
      if (s1_valid) begin
        dec_fi_o <= next_fi;
        dec_frames_o <= next_frames;
      end
    end
  end
endmodule : tdmf_frame_timing
`default_nettype wire

// >>> bench/tdmf_frame_timing_properties.sv
// Purpose: port checker for the frame timing block
// Assumes: one clock domain, srst_i synchronous
// Notes: bound from the testbench top
`timescale 1ns/1ps
`default_nettype none
module tdmf_frame_timing_checker #(
  parameter int NUM_HWY = 32
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic dec_req_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic [NUM_HWY-1:0] rx_vframe_o,
  input wire logic [NUM_HWY-1:0] tx_vframe_o,
  input wire logic device_ready_o,
  input wire logic dec_valid_o,
  input wire logic dec_fi_o,
  input wire logic [1:0] dec_frames_o
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  bus_okay_a:
    assert property (hreadyout_o && !hresp_o) else $error("bus answer not ready okay");
  dec_latency_a:
    assert property (dec_req_i && ce_i && device_ready_o |-> ##2 dec_valid_o)
    else $error("decision answer late");
  dec_cause_a:
    assert property (dec_valid_o |-> $past(dec_req_i, 2)) else $error("answer without request");
  ll_frames_a:
    assert property (dec_valid_o && !dec_fi_o |-> dec_frames_o <= 2'h1)
    else $error("low latency frame out of range");
  fi_frames_a:
    assert property (dec_valid_o && dec_fi_o |-> dec_frames_o != 2'h0)
    else $error("integrity slot sent in current frame");
  dec_hold_a:
    assert property (!dec_valid_o |-> $stable(dec_frames_o) && $stable(dec_fi_o))
    else $error("decision changed without answer");
  vframe_ready_a:
    assert property ((rx_vframe_o | tx_vframe_o) != '0 |-> device_ready_o)
    else $error("frame pulse while not ready");
  vframe_pulse_a:
    assert property (((rx_vframe_o & $past(rx_vframe_o)) | (tx_vframe_o & $past(tx_vframe_o)))
      == '0) else $error("frame pulse longer than one cycle");
  ready_hold_a:
    assert property (device_ready_o |=> device_ready_o) else $error("ready dropped");
  reset_quiet_a:
    assert property ($fell(srst_i) |-> !device_ready_o && !dec_valid_o && hrdata_o == 32'h0)
    else $error("outputs active out of reset");
endmodule : tdmf_frame_timing_checker
`default_nettype wire

// >>> bench/tdmf_hwy_model.sv
// Purpose: far end highway clock and frame sync source
// Assumes: free running highway clock, sync held one clock around its edge
// Notes: samp_o marks the cycle of the sync sampling edge
`timescale 1ns/1ps
`default_nettype none
module tdmf_hwy_model #(
  parameter int HALF = 4,
  parameter int FRAME = 2048
) (
  input wire logic sys_clk_i,
  input wire logic pol_i,
  input wire logic edge_i,
  output logic highway_clock_o,
  output logic frame_sync_o,
  output logic samp_o
);
  int div = 0;
  int h = 0;
  logic samp = 1'b0;
  logic act;
  // sync changes on the opposite clock edge, so it is stable when sampled
  assign act = edge_i ? (h <= 1) : (h == FRAME - 1 || h == 0);
  assign frame_sync_o = pol_i ? act : !act;
  assign highway_clock_o = h[0];
  assign samp_o = samp;
  always @(posedge sys_clk_i) begin
    div <= (div == HALF - 1) ? 0 : div + 1;
    samp <= (div == HALF - 1) && (((h + 1) % FRAME) == int'(edge_i));
    if (div == HALF - 1) h <= (h + 1) % FRAME;
  end
endmodule : tdmf_hwy_model
`default_nettype wire

// >>> bench/tdmf_frame_timing_tb.sv
// Purpose: self-checking bench for the frame timing block
// Assumes: lock count shortened to 40, highway clock 5 MHz, clock code 2
// Notes: frame pulses judged relative to the zero offset highway
`timescale 1ns/1ps
`default_nettype none
module tdmf_frame_timing_tb;
  // ------------------------------------------------------------
  // stimulus and wiring
  // ------------------------------------------------------------
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic req = 1'b0;
  logic [4:0] rxh = 5'h0;
  logic [4:0] txh = 5'h0;
  logic [6:0] rxs = 7'h0;
  logic [6:0] txs = 7'h0;
  logic pol = 1'b1;
  logic edg = 1'b1;
  wire logic hrdy, hresp, ready, dv, dfi, hck, fs, samp;
  wire logic [31:0] hrdata;
  wire logic [31:0] rxv;
  wire logic [31:0] txv;
  wire logic [1:0] dfr;
  int fails = 0;
  int check_count = 0;
  int t = 0;
  int rx_at[32];
  int tx_at[32];
  int rxo[7] = '{0, 96, 1984, 1984, 0, 3, 2047};
  int txi[7] = '{0, 1, 2, 3, 4, 6, 31};
  int txo[7] = '{0, 64, 63, 8, 2046, 0, 0};
  logic [31:0] cfg_tab[14] = '{32'h0100_0000, 32'h0104_1060, 32'h0108_2f81, 32'h010c_2f80,
    32'h0110_2000, 32'h0114_1003, 32'h0118_2fff, 32'h0200_0000, 32'h0204_0020, 32'h0208_207f,
    32'h020c_0004, 32'h0210_03ff, 32'h0218_2000, 32'h027c_2000};
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  tdmf_hwy_model #(.HALF(4), .FRAME(2048)) far (.sys_clk_i(sys_clk_i), .pol_i(pol),
    .edge_i(edg), .highway_clock_o(hck), .frame_sync_o(fs), .samp_o(samp));
  tdmf_frame_timing #(.LOCK_CYC(40)) dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp),
    .hrdata_o(hrdata), .highway_clock_i(hck), .frame_sync_i(fs), .rx_vframe_o(rxv),
    .tx_vframe_o(txv), .device_ready_o(ready), .dec_req_i(req), .dec_rx_hwy_i(rxh),
    .dec_rx_slot_i(rxs), .dec_tx_hwy_i(txh), .dec_tx_slot_i(txs), .dec_valid_o(dv),
    .dec_fi_o(dfi), .dec_frames_o(dfr));
  // pulse times in cycles since the sync sampling edge
  always @(posedge sys_clk_i) begin
    t <= samp ? 0 : t + 1;
    for (int h = 0; h < 32; h++) begin
      if (rxv[h]) rx_at[h] <= t;
      if (txv[h]) tx_at[h] <= t;
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic edge_rdy();
    do begin
      @(posedge sys_clk_i);
    end while (hrdy !== 1'b1);
  endtask : edge_rdy
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string what);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(what, e, r);
  endtask : rd
  task automatic wait_ready(input int lim);
    int n = 0;
    while (ready !== 1'b1 && n < lim) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk("device ready", 32'h1, {31'h0, ready});
  endtask : wait_ready
  task automatic wsamp();
    do begin
      @(posedge sys_clk_i);
    end while (samp !== 1'b1);
  endtask : wsamp
  task automatic frm(input logic p, input logic e);
    wr(32'h0, {26'h0, 2'h2, 1'b0, p, e, 1'b0});
    pol <= p;
    edg <= e;
    wsamp();
    wsamp();
    chk("tx vs rx start", rx_at[0], tx_at[0]);
    chk("sync to pulse", 32'h1, {31'h0, rx_at[0] < 4});
    for (int i = 0; i < 7; i++) begin
      chk("rx offset", rx_at[0] + 4 * rxo[i], rx_at[i]);
      chk("tx offset", tx_at[0] + 4 * txo[i], tx_at[txi[i]]);
    end
  endtask : frm
  task automatic dec(input logic [4:0] a, input logic [6:0] b, input logic [4:0] c,
                     input logic [6:0] d, input logic f, input logic [1:0] fr);
    int n = 0;
    wr(32'h4000 + 4 * (c * 128 + d), {31'h0, f});
    rxh <= a;
    rxs <= b;
    txh <= c;
    txs <= d;
    req <= 1'b1;
    @(posedge sys_clk_i);
    req <= 1'b0;
    while (dv !== 1'b1 && n < 10) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk("dec valid", 32'h1, {31'h0, dv});
    chk("dec fi", {31'h0, f}, {31'h0, dfi});
    chk("dec frames", {30'h0, fr}, {30'h0, dfr});
  endtask : dec
  task automatic results();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    logic [31:0] st;
    repeat (12) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    wait_ready(500);
    // ready in bit 0, lock in bit 1; position bits vary and are masked
    bus(1'b0, 32'h4, 32'h0, st);
    chk("status ready lock", 32'h3, {30'h0, st[1:0]});
    rd(32'h0, 32'h0, "gen cmd reset");
    foreach (cfg_tab[i]) wr({16'h0, cfg_tab[i][31:16]}, {16'h0, cfg_tab[i][15:0]});
    foreach (cfg_tab[i]) rd({16'h0, cfg_tab[i][31:16]}, {16'h0, cfg_tab[i][15:0]}, "cfg");
    rd(32'h0800, 32'h0, "unmapped");
    rd(32'h4000, 32'h0, "mode store read");
    for (int k = 0; k < 4; k++) frm(k[1], k[0]);
    dec(5'h0, 7'h0, 5'h0, 7'h3, 1'b0, 2'h0);
    dec(5'h0, 7'h0, 5'h0, 7'h2, 1'b0, 2'h1);
    dec(5'h4, 7'h2, 5'h1f, 7'h6, 1'b0, 2'h0);
    dec(5'h4, 7'h2, 5'h1f, 7'h5, 1'b0, 2'h1);
    dec(5'h1, 7'h5, 5'h6, 7'h15, 1'b0, 2'h0);
    dec(5'h1, 7'h5, 5'h6, 7'h14, 1'b0, 2'h1);
    dec(5'h0, 7'h0, 5'h1, 7'h0, 1'b1, 2'h1);
    dec(5'h0, 7'h0, 5'h2, 7'h0, 1'b1, 2'h2);
    dec(5'h2, 7'h0, 5'h0, 7'ha, 1'b1, 2'h3);
    dec(5'h3, 7'h0, 5'h0, 7'ha, 1'b1, 2'h2);
    srst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    chk("ready after reset", 32'h0, {31'h0, ready});
    wait_ready(12);
    rd(32'h0, 32'h0, "gen cmd after reset");
    results();
  end
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    fails++;
    results();
  end
endmodule : tdmf_frame_timing_tb
bind tdmf_frame_timing tdmf_frame_timing_checker #(.NUM_HWY(NUM_HWY)) chk_i (.sys_clk_i,
  .srst_i, .ce_i, .dec_req_i, .hreadyout_o, .hresp_o, .hrdata_o, .rx_vframe_o, .tx_vframe_o,
  .device_ready_o, .dec_valid_o, .dec_fi_o, .dec_frames_o);
`default_nettype wire
